// file: src/abcs_pkg.sv
// Constants, types and register map of the analog board configuration and status block.
package abcs_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ         = 200_000_000;
	localparam int unsigned CYC_PER_US     = CLK_HZ / 1_000_000;
	localparam int unsigned CYC_PER_MS     = CLK_HZ / 1_000;
	// Feedback PWM period, 1 kHz.
	localparam int unsigned PWM_PERIOD_US  = 1000;
	localparam int unsigned PWM_PERIOD_CYC = PWM_PERIOD_US * CYC_PER_US;
	// LED half periods: fast flash 4 Hz, slow flash 1 Hz.
	localparam int unsigned LED_FAST_MS    = 125;
	localparam int unsigned LED_FAST_CYC   = LED_FAST_MS * CYC_PER_MS;
	localparam int unsigned LED_SLOW_MS    = 500;
	localparam int unsigned LED_SLOW_CYC   = LED_SLOW_MS * CYC_PER_MS;
	// Power-on display window.
	localparam int unsigned STARTUP_MS     = 5000;
	localparam int unsigned STARTUP_CYC    = STARTUP_MS * CYC_PER_MS;
	// Cycles after reset before the switch pattern is taken.
	localparam int unsigned SETTLE_CYC     = 8;

	// ----------------------------------------------------------------
	// Package selection
	// ----------------------------------------------------------------
	localparam int unsigned SW_W           = 6;
	localparam logic [5:0]  PKG_CODE_A     = 6'h2c;
	localparam logic [5:0]  PKG_CODE_B     = 6'h2d;
	localparam logic [7:0]  ERR_BAD_CODE   = 8'h27;

	// ----------------------------------------------------------------
	// Duty levels in quarters of the period
	// ----------------------------------------------------------------
	localparam logic [2:0]  DUTY_0         = 3'h0;
	localparam logic [2:0]  DUTY_25        = 3'h1;
	localparam logic [2:0]  DUTY_50        = 3'h2;
	localparam logic [2:0]  DUTY_75        = 3'h3;
	localparam logic [2:0]  DUTY_100       = 3'h4;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_STATUS     = 8'h00;
	localparam logic [7:0]  REG_IRQ_STAT   = 8'h04;
	localparam logic [7:0]  REG_IRQ_MASK   = 8'h08;
	localparam int unsigned ST_CODE_LSB    = 0;
	localparam int unsigned ST_SAMPLED     = 8;
	localparam int unsigned ST_BAD         = 9;
	localparam int unsigned ST_JUMPER      = 10;
	localparam int unsigned ST_BRIDGE      = 11;
	localparam int unsigned ST_LIMIT       = 12;
	localparam int unsigned ST_LED         = 13;
	localparam int unsigned ST_STATE_LSB   = 16;
	localparam int unsigned ST_DUTY_LSB    = 20;
	localparam int unsigned IRQ_SAMPLED    = 0;
	localparam int unsigned IRQ_BAD        = 1;
	localparam int unsigned IRQ_FAULT      = 2;
	localparam int unsigned IRQ_SDP        = 3;
	localparam int unsigned IRQ_W          = 4;
	localparam logic [3:0]  IRQ_MASK_RST   = 4'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_STARTUP,
		ST_BADCODE,
		ST_ERROR,
		ST_SDP,
		ST_RUN,
		ST_STANDBY
	} abcs_state_e;

	typedef enum logic [1:0] {
		DISP_PACKAGE,
		DISP_ERROR,
		DISP_STATUS
	} abcs_disp_e;

	typedef struct packed {
		logic trip;
		logic gen_err;
		logic speed_drop_protection;
		logic running;
		logic heating;
	} abcs_drv_s;

	typedef struct packed {
		abcs_disp_e sel;
		logic [7:0] val;
	} abcs_disp_s;

endpackage

// file: src/abcs_pin_sync.sv
// Three-stage pin synchroniser with agreement filter, one per bit.
`timescale 1ns/1ps
module abcs_pin_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] val_o
);

	generate
		if (W < 1) begin : g_chk
			$error("abcs_pin_sync needs W of at least one");
		end
		for (genvar i = 0; i < W; i++) begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic out_q;
			// The first stage feeds only the second; the filter looks at stages two and three.
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					s1_q  <= 1'b0;
					s2_q  <= 1'b0;
					s3_q  <= 1'b0;
					out_q <= 1'b0;
				end else begin
					s1_q <= pin_i[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						out_q <= s3_q;
					end
				end
			end
			assign val_o[i] = out_q;
		end
	endgenerate

endmodule

// file: src/abcs_pwm.sv
// Fixed-period PWM generator whose duty is taken only at period boundaries.
`timescale 1ns/1ps
module abcs_pwm #(
	parameter int unsigned PERIOD = abcs_pkg::PWM_PERIOD_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [2:0] duty_i,
	output logic            pwm_o,
	output logic [2:0]      duty_o
);

	localparam int unsigned QUARTER = PERIOD / 4;

	generate
		if (PERIOD < 4 || (PERIOD % 4) != 0) begin : g_chk
			$error("abcs_pwm needs a period that is a multiple of four");
		end
	endgenerate

	logic [31:0] cnt_q;
	logic [31:0] thr_q;
	logic [2:0]  duty_q;
	logic        pwm_q;
	wire         wrap = (cnt_q == 32'(PERIOD - 1));
	wire  [2:0]  duty_lim = (duty_i > abcs_pkg::DUTY_100) ? abcs_pkg::DUTY_100 : duty_i;

	// Latching the duty at the wrap keeps every period a clean level to the reader.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q  <= 32'h0;
			thr_q  <= 32'h0;
			duty_q <= abcs_pkg::DUTY_0;
			pwm_q  <= 1'b0;
		end else begin
			cnt_q <= wrap ? 32'h0 : cnt_q + 32'h1;
			if (wrap) begin
				thr_q  <= 32'(duty_lim) * 32'(QUARTER);
				duty_q <= duty_lim;
			end
			pwm_q <= (cnt_q < thr_q);
		end
	end

	assign pwm_o  = pwm_q;
	assign duty_o = duty_q;

endmodule

// file: src/abcs_top.sv
// Analog board configuration and status logic with a classic Wishbone register slave.
// Function
// - No feedback jumper: duty 0 percent when tripped, 100 percent when OK.
// - Jumper fitted: 0 error, 25 bad code, 50 standby, 75 speed drop, 100 run.
// - Package selection comes from six switches, ON reads 1, OFF reads 0.
// - Switches are sampled once after reset; later changes are ignored.
// - Invalid pattern shows error 39 and holds feedback at 25 percent.
// - Invalid code fault stays latched until the next power cycle.
// - Switch positions 1 to 6 each give one bit of the pattern.
// - Position 6 is the most significant bit, position 1 the least.
// - During start-up the display shows the selected package code.
// - LED flashes fast on fault, slowly in standby, steady when running.
// - No bridge selects mode 0 limited range; bridge selects mode 1 full range.
// - During speed drop protection the limited range is forced.
//
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
module abcs_top #(
	parameter int unsigned PWM_PERIOD_CYC = abcs_pkg::PWM_PERIOD_CYC,
	parameter int unsigned LED_FAST_CYC   = abcs_pkg::LED_FAST_CYC,
	parameter int unsigned LED_SLOW_CYC   = abcs_pkg::LED_SLOW_CYC,
	parameter int unsigned STARTUP_CYC    = abcs_pkg::STARTUP_CYC
) (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Board pins.
	input  wire logic [5:0]          pkg_sw_i,
	input  wire logic                fb_jumper_i,
	input  wire logic                range_bridge_i,
	// Drive status.
	input  wire abcs_pkg::abcs_drv_s drive_i,
	// Board outputs.
	output logic                     fb_pwm_o,
	output logic                     status_led_o,
	output logic                     env_mode_o,
	output logic                     limit_range_o,
	output abcs_pkg::abcs_disp_s     disp_o,
	output logic                     irq_o,
	// Wishbone slave.
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic [31:0]              wb_dat_o,
	output logic                     wb_ack_o
);

	generate
		if (LED_FAST_CYC < 1 || LED_SLOW_CYC < 1 || STARTUP_CYC < 1) begin : g_chk
			$error("abcs_top needs counts of at least one");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [7:0] pins_s;

	abcs_pin_sync #(
		.W (8)
	) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.pin_i ({range_bridge_i, fb_jumper_i, pkg_sw_i}),
		.val_o (pins_s)
	);

	wire [5:0] sw_s     = pins_s[5:0];
	wire       jumper_s = pins_s[6];
	wire       bridge_s = pins_s[7];

	// ----------------------------------------------------------------
	// One-time package sampling
	// ----------------------------------------------------------------
	logic [3:0]  settle_q;
	logic        sampled_q;
	logic [5:0]  code_q;
	logic        bad_q;
	logic [31:0] start_q;
	logic        startup_q;

	wire settle_done = (settle_q == 4'(abcs_pkg::SETTLE_CYC));
	wire take_code   = settle_done && !sampled_q;
	wire code_ok     = (sw_s == abcs_pkg::PKG_CODE_A) || (sw_s == abcs_pkg::PKG_CODE_B);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			settle_q  <= 4'h0;
			sampled_q <= 1'b0;
			code_q    <= 6'h0;
		end else begin
			if (!settle_done) begin
				settle_q <= settle_q + 4'h1;
			end
			if (take_code) begin
				sampled_q <= 1'b1;
				code_q    <= sw_s;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bad_q <= 1'b0;
		end else if (take_code && !code_ok) begin
			bad_q <= 1'b1;
		end
	end

	// The start-up window runs once from reset; it is not restarted by anything else.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_q   <= 32'h0;
			startup_q <= 1'b1;
		end else if (startup_q) begin
			start_q <= start_q + 32'h1;
			if (start_q == 32'(STARTUP_CYC - 1)) begin
				startup_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Board state
	// ----------------------------------------------------------------
	abcs_pkg::abcs_state_e state_q;
	abcs_pkg::abcs_state_e state_d;

	wire drv_fault = drive_i.trip || drive_i.gen_err;
	wire drv_run   = drive_i.running || drive_i.heating;

	always_comb begin
		if (bad_q) begin
			state_d = abcs_pkg::ST_BADCODE;
		end else if (!sampled_q) begin
			state_d = abcs_pkg::ST_STARTUP;
		end else if (drv_fault) begin
			state_d = abcs_pkg::ST_ERROR;
		end else if (drive_i.speed_drop_protection) begin
			state_d = abcs_pkg::ST_SDP;
		end else if (drv_run) begin
			state_d = abcs_pkg::ST_RUN;
		end else if (startup_q) begin
			state_d = abcs_pkg::ST_STARTUP;
		end else begin
			state_d = abcs_pkg::ST_STANDBY;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= abcs_pkg::ST_STARTUP;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// Feedback duty
	// ----------------------------------------------------------------
	logic [2:0] duty_sel;
	logic [2:0] duty_now;

	always_comb begin
		duty_sel = abcs_pkg::DUTY_50;
		if (!jumper_s) begin
			duty_sel = (state_q == abcs_pkg::ST_ERROR) ? abcs_pkg::DUTY_0 : abcs_pkg::DUTY_100;
		end else begin
			unique case (state_q)
				abcs_pkg::ST_ERROR:   duty_sel = abcs_pkg::DUTY_0;
				abcs_pkg::ST_SDP:     duty_sel = abcs_pkg::DUTY_75;
				abcs_pkg::ST_RUN:     duty_sel = abcs_pkg::DUTY_100;
				abcs_pkg::ST_BADCODE: duty_sel = abcs_pkg::DUTY_25;
				abcs_pkg::ST_STARTUP: duty_sel = abcs_pkg::DUTY_50;
				abcs_pkg::ST_STANDBY: duty_sel = abcs_pkg::DUTY_50;
			endcase
		end
		if (state_q == abcs_pkg::ST_BADCODE) begin
			duty_sel = abcs_pkg::DUTY_25;
		end
	end

	abcs_pwm #(
		.PERIOD (PWM_PERIOD_CYC)
	) u_pwm (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.duty_i (duty_sel),
		.pwm_o  (fb_pwm_o),
		.duty_o (duty_now)
	);

	// ----------------------------------------------------------------
	// Status LED
	// ----------------------------------------------------------------
	logic [31:0] fast_cnt_q;
	logic [31:0] slow_cnt_q;
	logic        fast_q;
	logic        slow_q;
	logic        led_q;

	wire fast_tick = (fast_cnt_q == 32'(LED_FAST_CYC - 1));
	wire slow_tick = (slow_cnt_q == 32'(LED_SLOW_CYC - 1));
	wire is_fault  = (state_q == abcs_pkg::ST_ERROR) || (state_q == abcs_pkg::ST_BADCODE);
	wire is_run    = (state_q == abcs_pkg::ST_RUN) || (state_q == abcs_pkg::ST_SDP);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fast_cnt_q <= 32'h0;
			slow_cnt_q <= 32'h0;
			fast_q     <= 1'b0;
			slow_q     <= 1'b0;
		end else begin
			fast_cnt_q <= fast_tick ? 32'h0 : fast_cnt_q + 32'h1;
			slow_cnt_q <= slow_tick ? 32'h0 : slow_cnt_q + 32'h1;
			if (fast_tick) begin
				fast_q <= !fast_q;
			end
			if (slow_tick) begin
				slow_q <= !slow_q;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			led_q <= 1'b0;
		end else begin
			led_q <= is_fault ? fast_q : (is_run ? 1'b1 : slow_q);
		end
	end

	assign status_led_o = led_q;

	// ----------------------------------------------------------------
	// Speed range and display
	// ----------------------------------------------------------------
	logic                 mode_q;
	logic                 limit_q;
	abcs_pkg::abcs_disp_s disp_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_q  <= 1'b0;
			limit_q <= 1'b1;
		end else begin
			mode_q  <= bridge_s;
			limit_q <= !bridge_s || drive_i.speed_drop_protection;
		end
	end

	assign env_mode_o    = mode_q;
	assign limit_range_o = limit_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			disp_q.sel <= abcs_pkg::DISP_PACKAGE;
			disp_q.val <= 8'h0;
		end else if (bad_q) begin
			disp_q.sel <= abcs_pkg::DISP_ERROR;
			disp_q.val <= abcs_pkg::ERR_BAD_CODE;
		end else if (startup_q) begin
			disp_q.sel <= abcs_pkg::DISP_PACKAGE;
			disp_q.val <= {2'b00, code_q};
		end else begin
			disp_q.sel <= abcs_pkg::DISP_STATUS;
			disp_q.val <= {5'h0, state_q};
		end
	end

	assign disp_o = disp_q;

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	localparam int unsigned IW = abcs_pkg::IRQ_W;

	logic [IW-1:0] irq_stat_q;
	logic [IW-1:0] irq_mask_q;
	logic          fault_d1_q;
	logic          sdp_d1_q;

	wire is_sdp = (state_q == abcs_pkg::ST_SDP);
	wire [IW-1:0] irq_ev = {
		is_sdp && !sdp_d1_q,
		is_fault && !fault_d1_q,
		take_code && !code_ok,
		take_code
	};

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	logic        ack_q;
	logic [31:0] rdat_q;

	wire req      = wb_cyc_i && wb_stb_i;
	wire wr_fire  = req && wb_we_i && ack_q;
	wire hit_stat = (wb_adr_i == abcs_pkg::REG_IRQ_STAT);
	wire hit_mask = (wb_adr_i == abcs_pkg::REG_IRQ_MASK);
	wire [IW-1:0] irq_clr = (wr_fire && hit_stat && wb_sel_i[0]) ? wb_dat_i[IW-1:0] : '0;

	wire [31:0] status_word =
		(32'(code_q) << abcs_pkg::ST_CODE_LSB) |
		(32'(sampled_q) << abcs_pkg::ST_SAMPLED) |
		(32'(bad_q) << abcs_pkg::ST_BAD) |
		(32'(jumper_s) << abcs_pkg::ST_JUMPER) |
		(32'(bridge_s) << abcs_pkg::ST_BRIDGE) |
		(32'(limit_q) << abcs_pkg::ST_LIMIT) |
		(32'(led_q) << abcs_pkg::ST_LED) |
		(32'(state_q) << abcs_pkg::ST_STATE_LSB) |
		(32'(duty_now) << abcs_pkg::ST_DUTY_LSB);

	wire [31:0] rd_mux =
		(wb_adr_i == abcs_pkg::REG_STATUS) ? status_word :
		hit_stat ? 32'(irq_stat_q) :
		hit_mask ? 32'(irq_mask_q) : 32'h0;

	// A new event in the clearing cycle survives because the set term is applied last.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_q <= '0;
			irq_mask_q <= abcs_pkg::IRQ_MASK_RST;
			fault_d1_q <= 1'b0;
			sdp_d1_q   <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
			fault_d1_q <= is_fault;
			sdp_d1_q   <= is_sdp;
			if (wr_fire && hit_mask && wb_sel_i[0]) begin
				irq_mask_q <= wb_dat_i[IW-1:0];
			end
		end
	end

	assign irq_o = |(irq_stat_q & irq_mask_q);

	// Ack comes one cycle after the strobe and drops in the cycle after it was given.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0;
		end else begin
			ack_q <= req && !ack_q;
			if (req && !ack_q) begin
				rdat_q <= rd_mux;
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

endmodule

// file: tb/abcs_top_monitor.sv
// Concurrent checks on the ports of the configuration and status block.
`timescale 1ns/1ps
module abcs_top_monitor #(
	parameter int unsigned PWM_PERIOD_CYC = 16
) (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                range_bridge_i,
	input  wire abcs_pkg::abcs_drv_s drive_i,
	input  wire logic                fb_pwm_o,
	input  wire logic                status_led_o,
	input  wire logic                env_mode_o,
	input  wire logic                limit_range_o,
	input  wire abcs_pkg::abcs_disp_s disp_o,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_ack_o
);
	// ----------------------------------------------------------------
	// Helper counters
	// ----------------------------------------------------------------
	// Age saturates well past the sampling point so start-up states are skipped.
	logic [5:0] age_q;
	logic [7:0] hi_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			age_q <= 6'h00;
			hi_q  <= 8'h00;
		end else begin
			age_q <= (age_q == 6'h3f) ? age_q : age_q + 6'h01;
			hi_q  <= fb_pwm_o ? hi_q + 8'h01 : 8'h00;
		end
	end
	wire logic settled = (age_q == 6'h3f);
	wire logic err_shown = (disp_o.sel == abcs_pkg::DISP_ERROR);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_wb_taken;
		(wb_cyc_i && wb_stb_i && !wb_ack_o) ##1 wb_ack_o;
	endsequence
	sequence s_sdp_held;
		drive_i.speed_drop_protection [*4];
	endsequence
	sequence s_run_held;
		(settled && !err_shown && drive_i.running && !drive_i.trip && !drive_i.gen_err) [*4];
	endsequence

	chk_ack_pulse: assert property (s_wb_taken |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_pwm_quarter: assert property ($fell(fb_pwm_o) |-> hi_q % (PWM_PERIOD_CYC / 4) == 0)
		else $error("feedback high time not a whole quarter");
	chk_bad_duty: assert property (settled && err_shown && $fell(fb_pwm_o)
		|-> hi_q == PWM_PERIOD_CYC / 4)
		else $error("bad code feedback not at one quarter");
	chk_err_code: assert property (err_shown |-> disp_o.val == abcs_pkg::ERR_BAD_CODE)
		else $error("wrong error number on display");
	chk_err_latch: assert property (err_shown |=> err_shown)
		else $error("bad code fault left without reset");
	chk_sdp_limit: assert property (s_sdp_held |-> limit_range_o)
		else $error("limited range not forced in speed drop");
	sequence s_bridge_held;
		range_bridge_i [*6];
	endsequence
	chk_mode_bridge: assert property (!limit_range_o |-> env_mode_o)
		else $error("full range without mode one");
	chk_bridge_mode: assert property (s_bridge_held |-> env_mode_o)
		else $error("bridge fitted without mode one");
	chk_led_steady: assert property (s_run_held |-> status_led_o)
		else $error("led not steady while running");
endmodule

// file: tb/abcs_fb_reader.sv
// External controller model that reads the feedback PWM as a high count per period.
`timescale 1ns/1ps
module abcs_fb_reader #(
	parameter int unsigned PERIOD = 16
) (
	input  wire logic  clk_i,
	input  wire logic  pwm_i,
	output logic [7:0] high_cnt_o
);
	// A sliding window of one period gives the high count whatever the phase.
	logic [PERIOD-1:0] win_q;
	always_ff @(posedge clk_i) begin
		win_q <= {win_q[PERIOD-2:0], pwm_i};
	end
	always_comb begin
		high_cnt_o = 8'h00;
		for (int i = 0; i < PERIOD; i++) begin
			high_cnt_o = high_cnt_o + 8'(win_q[i]);
		end
	end
endmodule

// file: tb/test_analog_board_config_status.sv
// Self-checking testbench of the configuration and status block.
`timescale 1ns/1ps
module test_analog_board_config_status;
	logic clk = 1'b0, rst = 1'b1, jmp = 1'b0, brg = 1'b0;
	logic [5:0] sw = 6'h2d;
	abcs_pkg::abcs_drv_s drv = '0;
	logic fb, led, envm, lim, irq, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
	abcs_pkg::abcs_disp_s disp;
	logic [7:0] adr = 8'h00, hc;
	logic [31:0] wdat = 32'h0, rdat, r;
	logic [3:0] sel = 4'h0, lanes = 4'hf;
	int n_mismatch = 0, tests_run = 0, k;
	typedef struct { logic j; logic [4:0] d; logic [2:0] q; } abcs_row_s;
	abcs_row_s rows [12] = '{'{0,5'h10,0}, '{0,5'h00,4}, '{0,5'h02,4}, '{0,5'h04,4},
		'{1,5'h08,0}, '{1,5'h10,0}, '{1,5'h00,2}, '{1,5'h04,3}, '{1,5'h02,4},
		'{1,5'h01,4}, '{1,5'h0c,0}, '{1,5'h06,3}};
	always #2.5 clk = ~clk;

	abcs_top #(.PWM_PERIOD_CYC(16), .LED_FAST_CYC(4), .LED_SLOW_CYC(8), .STARTUP_CYC(50)) u_abcs_top (
		.clk_i(clk), .rst_i(rst), .pkg_sw_i(sw), .fb_jumper_i(jmp), .range_bridge_i(brg),
		.drive_i(drv), .fb_pwm_o(fb), .status_led_o(led), .env_mode_o(envm), .limit_range_o(lim),
		.disp_o(disp), .irq_o(irq), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
	abcs_fb_reader #(.PERIOD(16)) u_abcs_fb_reader (.clk_i(clk), .pwm_i(fb), .high_cnt_o(hc));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= lanes;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask
	task automatic do_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
	endtask
	task automatic led_toggles(input int exp);
		int t;
		logic p;
		t = 0;
		p = led;
		repeat (32) begin
			@(posedge clk);
			if (led !== p) t++;
			p = led;
		end
		chk(t, exp, "led toggles");
	endtask
	task report_and_stop();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	initial begin
		#100000;
		n_mismatch++;
		report_and_stop();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		chk({envm, lim}, 2'b01, "bridge absent");
		wb(1'b0, abcs_pkg::REG_IRQ_MASK, 0); chk(r, 0, "mask reset");
		repeat (16) @(posedge clk);
		chk({disp.sel, disp.val[5:0]}, {abcs_pkg::DISP_PACKAGE, 6'h2d}, "startup display");
		sw <= 6'h00; brg <= 1'b1;
		repeat (60) @(posedge clk);
		wb(1'b0, abcs_pkg::REG_STATUS, 0); chk(r[9:0], 10'h12d, "sampled code");
		chk(irq, 1'b0, "masked irq");
		led_toggles(4);
		foreach (rows[i]) begin
			jmp <= rows[i].j; drv <= rows[i].d;
			repeat (40) @(posedge clk);
			chk(hc, 4 * rows[i].q, "feedback duty");
			chk(lim, rows[i].d[2], "speed range limit");
			wb(1'b0, abcs_pkg::REG_STATUS, 0); chk(r[22:20], rows[i].q, "duty field");
		end
		wb(1'b0, abcs_pkg::REG_IRQ_STAT, 0); chk(r[3:0], 4'hd, "events");
		wb(1'b1, abcs_pkg::REG_IRQ_MASK, 4);
		@(posedge clk);
		chk(irq, 1'b1, "irq raised");
		// A write without byte lane zero must leave the mask alone.
		lanes = 4'he;
		wb(1'b1, abcs_pkg::REG_IRQ_MASK, 15);
		lanes = 4'hf;
		wb(1'b0, abcs_pkg::REG_IRQ_MASK, 0); chk(r, 4, "lane zero off");
		wb(1'b1, abcs_pkg::REG_IRQ_STAT, 15); wb(1'b0, abcs_pkg::REG_IRQ_STAT, 0);
		chk({irq, r[3:0]}, 5'h00, "irq cleared");
		wb(1'b1, abcs_pkg::REG_STATUS, 32'hffff_ffff); wb(1'b0, 8'hfc, 0); chk(r, 0, "unmapped");
		wb(1'b0, abcs_pkg::REG_STATUS, 0); chk(r[5:0], 6'h2d, "read only status");
		// Pattern of a valid code read in reverse order must be refused.
		sw <= 6'h0d; jmp <= 1'b0; drv <= '0;
		do_reset();
		repeat (60) @(posedge clk);
		chk(disp, {abcs_pkg::DISP_ERROR, 8'h27}, "bad code display");
		chk(hc, 4, "bad code duty");
		led_toggles(8);
		sw <= 6'h2d;
		repeat (40) @(posedge clk);
		wb(1'b0, abcs_pkg::REG_STATUS, 0); chk(r[9], 1'b1, "fault latched");
		do_reset();
		repeat (20) @(posedge clk);
		chk(disp, {abcs_pkg::DISP_PACKAGE, 8'h2d}, "fault cleared");
		report_and_stop();
	end
endmodule

bind abcs_top abcs_top_monitor #(.PWM_PERIOD_CYC(PWM_PERIOD_CYC)) u_abcs_top_monitor (
	.clk_i(clk_i), .rst_i(rst_i), .range_bridge_i(range_bridge_i), .drive_i(drive_i),
	.fb_pwm_o(fb_pwm_o), .status_led_o(status_led_o), .env_mode_o(env_mode_o),
	.limit_range_o(limit_range_o), .disp_o(disp_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o));
